/* hdc_pkg.sv */
package hdc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] DEV_CFG_OFFSET    = 8'h05; // device configuration
  localparam logic [7:0] CHG_PORT_OFFSET   = 8'h06; // charge-port enables

  // ----------------------------------------------------------------
  // device configuration field positions
  // ----------------------------------------------------------------
  localparam int STR_WE_BIT    = 7; // string write enable
  localparam int SER_WE_BIT    = 6; // serial number write enable
  localparam int LPL_DIS_BIT   = 5; // low-power link disable
  localparam int RSVD_ONE_BIT  = 4; // reads as one
  localparam int SHARED_BIT    = 3; // shared power switch
  localparam int PM_OFF_BIT    = 2; // power management off
  localparam int RSVD_RW_BIT   = 1; // reserved, writable
  localparam int RSVD_ZERO_BIT = 0; // reads as zero

  // writable masks
  localparam logic [7:0] DEV_CFG_WMASK     = 8'hee;
  localparam logic [7:0] CHG_PORT_WMASK    = 8'h03;

  // reset values of non-strapped fields
  localparam logic [7:0] DEV_CFG_RESET     = 8'h10;
  localparam logic [7:0] CHG_PORT_RESET    = 8'h00;

  // strap capture: edge count after release, and where the count parks
  localparam logic [1:0] STRAP_CAPTURE_CNT = 2'h2;
  localparam logic [1:0] STRAP_DONE_CNT    = 2'h3;

  // ----------------------------------------------------------------
  // load sources
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    HDC_MODE_PIN,
    HDC_MODE_I2C,
    HDC_MODE_SMBUS
  } hdc_mode_e;

  // register access request from eeprom loader or smbus slave
  typedef struct packed {
    logic       wr;   // write strobe
    logic       rd;   // read strobe
    logic [7:0] addr; // register offset
    logic [7:0] data; // write data
  } hdc_req_s;

  // straps sampled at reset release
  typedef struct packed {
    logic       shared_power;
    logic       power_mgmt;
    logic [1:0] charge_enables;
  } hdc_strap_s;

endpackage

/* hdc_config_regs.sv */
`timescale 1ns/1ps
module hdc_config_regs (
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  // load mode and access
  input  wire hdc_pkg::hdc_mode_e i_mode,
  input  wire hdc_pkg::hdc_req_s i_req,
  output logic [7:0]             o_rdata,
  // straps from pins
  input  wire hdc_pkg::hdc_strap_s i_strap,
  // link power events
  input  wire logic              i_force_accept,
  input  wire logic              i_upstream_disconnect,
  input  wire logic              i_link_lp_request,
  output logic                   o_link_lp_allow,
  // port power demand from hub
  input  wire logic [1:0]        i_port_power_req,
  output logic [1:0]             o_port_power_charge,
  output logic                   o_power_switching_en,
  // downstream write gates and charge enables
  output logic                   o_string_write_enable,
  output logic                   o_serial_number_write_enable,
  output logic [1:0]             o_charge_port_enables
);

  // ----------------------------------------------------------------
  // strap synchroniser and release capture
  // ----------------------------------------------------------------
  hdc_pkg::hdc_strap_s strap_s1_r;   // first stage
  hdc_pkg::hdc_strap_s strap_s2_r;   // second stage
  logic [1:0]          rel_cnt_r;    // cycles since release
  logic                capture;      // strap capture strobe

  // two-flop strap sync
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      strap_s1_r <= '0;
      strap_s2_r <= '0;
    end else begin
      strap_s1_r <= i_strap;
      strap_s2_r <= strap_s1_r;
    end
  end

  // count edges after release until sync is filled
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rel_cnt_r <= 2'h0;
    end else if (rel_cnt_r != hdc_pkg::STRAP_DONE_CNT) begin
      rel_cnt_r <= rel_cnt_r + 2'h1;
    end
  end

  // capture once second stage holds pin level
  assign capture = (rel_cnt_r == hdc_pkg::STRAP_CAPTURE_CNT);

  // ----------------------------------------------------------------
  // register write qualification
  // ----------------------------------------------------------------
  logic loader_mode;  // eeprom or smbus may write
  logic wr_cfg;       // write to device configuration
  logic wr_chg;       // write to charge-port enables

  // writes only from eeprom loader or smbus host
  assign loader_mode = (i_mode == hdc_pkg::HDC_MODE_I2C) ||
                       (i_mode == hdc_pkg::HDC_MODE_SMBUS);
  assign wr_cfg = loader_mode && i_req.wr &&
                  (i_req.addr == hdc_pkg::DEV_CFG_OFFSET);
  assign wr_chg = loader_mode && i_req.wr &&
                  (i_req.addr == hdc_pkg::CHG_PORT_OFFSET);

  // ----------------------------------------------------------------
  // device configuration register
  // ----------------------------------------------------------------
  logic [7:0] dev_cfg_r;    // stored writable bits
  logic [7:0] dev_cfg_rd;   // read view

  // write, strap capture; writable bits only
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dev_cfg_r <= hdc_pkg::DEV_CFG_RESET & hdc_pkg::DEV_CFG_WMASK;
    end else if (capture) begin
      // straps win over any early write
      dev_cfg_r[hdc_pkg::SHARED_BIT] <= strap_s2_r.shared_power;
      dev_cfg_r[hdc_pkg::PM_OFF_BIT] <= strap_s2_r.power_mgmt;
    end else if (wr_cfg) begin
      // masked write keeps fixed bits out
      dev_cfg_r <= i_req.data & hdc_pkg::DEV_CFG_WMASK;
    end
  end

  // fixed bits forced on read
  always_comb begin
    dev_cfg_rd = dev_cfg_r & hdc_pkg::DEV_CFG_WMASK;
    dev_cfg_rd[hdc_pkg::RSVD_ONE_BIT]  = 1'b1;
    dev_cfg_rd[hdc_pkg::RSVD_ZERO_BIT] = 1'b0;
  end

  // write gates for string and serial registers
  assign o_string_write_enable        = dev_cfg_r[hdc_pkg::STR_WE_BIT];
  assign o_serial_number_write_enable = dev_cfg_r[hdc_pkg::SER_WE_BIT];

  // ----------------------------------------------------------------
  // charge-port enables register
  // ----------------------------------------------------------------
  logic [1:0] chg_r;  // per-port charge enables

  // strap load then eeprom or smbus overwrite
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      chg_r <= hdc_pkg::CHG_PORT_RESET[1:0];
    end else if (capture) begin
      chg_r <= strap_s2_r.charge_enables;
    end else if (wr_chg) begin
      chg_r <= i_req.data[1:0] & hdc_pkg::CHG_PORT_WMASK[1:0];
    end
  end

  // bit 0 port 1, bit 1 port 2
  assign o_charge_port_enables = chg_r;

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  // registered read; unmapped reads zero
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_req.rd) begin
      case (i_req.addr)
        hdc_pkg::DEV_CFG_OFFSET:  o_rdata <= dev_cfg_rd;
        hdc_pkg::CHG_PORT_OFFSET: o_rdata <= {6'h00, chg_r};
        default:                  o_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // link power management gating
  // ----------------------------------------------------------------
  logic force_held_r;  // forced accept seen

  // latch forced accept until disconnect or reset
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      force_held_r <= 1'b0;
    end else if (i_force_accept) begin
      force_held_r <= 1'b1;
    end else if (i_upstream_disconnect) begin
      force_held_r <= 1'b0;
    end
  end

  // u1/u2 allowed unless disabled and not forced
  assign o_link_lp_allow = i_link_lp_request &&
      (!dev_cfg_r[hdc_pkg::LPL_DIS_BIT] || force_held_r || i_force_accept);

  // ----------------------------------------------------------------
  // port power switching
  // ----------------------------------------------------------------
  logic [1:0] pwr_nxt;  // next power pin drive
  logic [1:0] pwr_r;    // registered power pins

  // gang on port 1 pin, else per port
  always_comb begin
    pwr_nxt = 2'b00;
    if (!dev_cfg_r[hdc_pkg::PM_OFF_BIT]) begin
      if (dev_cfg_r[hdc_pkg::SHARED_BIT]) begin
        pwr_nxt[0] = |i_port_power_req;
      end else begin
        pwr_nxt = i_port_power_req;
      end
    end
  end

  // registered pin drive
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pwr_r <= 2'b00;
    end else begin
      pwr_r <= pwr_nxt;
    end
  end

  assign o_port_power_charge  = pwr_r;
  assign o_power_switching_en = !dev_cfg_r[hdc_pkg::PM_OFF_BIT];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // short names for the guarded fields
  logic pm_on;          // port power switching on
  logic shared_sw;      // ganged switching chosen
  logic lp_dis;         // u1/u2 disabled
  logic addr_unmapped;  // offset outside the pair
  assign pm_on         = !dev_cfg_r[hdc_pkg::PM_OFF_BIT];
  assign shared_sw     = dev_cfg_r[hdc_pkg::SHARED_BIT];
  assign lp_dis        = dev_cfg_r[hdc_pkg::LPL_DIS_BIT];
  assign addr_unmapped = (i_req.addr != hdc_pkg::DEV_CFG_OFFSET) &&
                         (i_req.addr != hdc_pkg::CHG_PORT_OFFSET);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // fixed read bits of device configuration
  rsvd_one_a: assert property (dev_cfg_rd[hdc_pkg::RSVD_ONE_BIT]
      && !dev_cfg_rd[hdc_pkg::RSVD_ZERO_BIT])
    else $error("fixed bits of device configuration wrong");

  // upper charge bits never leave the read port
  chg_rsvd_a: assert property (i_req.rd && i_req.addr == hdc_pkg::CHG_PORT_OFFSET
      |=> o_rdata[7:2] == 6'h00)
    else $error("charge register upper bits not zero");

  // straps land in the register one edge after capture
  strap_cap_a: assert property (capture
      |=> dev_cfg_r[hdc_pkg::SHARED_BIT] == $past(strap_s2_r.shared_power)
      && dev_cfg_r[hdc_pkg::PM_OFF_BIT] == $past(strap_s2_r.power_mgmt))
    else $error("straps not captured");

  chg_strap_a: assert property (capture
      |=> chg_r == $past(strap_s2_r.charge_enables))
    else $error("charge straps not captured");

  // switching enable follows the power strap
  sw_en_a: assert property (capture
      |=> o_power_switching_en == !$past(strap_s2_r.power_mgmt))
    else $error("switching enable does not follow strap");

  capture_once_a: assert property (capture
      |=> !capture)
    else $error("strap capture repeated");

  // loader and host writes reach the stored bits
  cfg_write_a: assert property (wr_cfg && !capture
      |=> dev_cfg_r == ($past(i_req.data) & hdc_pkg::DEV_CFG_WMASK))
    else $error("config write not taken");

  // write gates follow the written bits
  we_gate_a: assert property (wr_cfg && !capture
      |=> o_string_write_enable == $past(i_req.data[hdc_pkg::STR_WE_BIT])
      && o_serial_number_write_enable == $past(i_req.data[hdc_pkg::SER_WE_BIT]))
    else $error("write gates disagree with written value");

  rsvd_store_a: assert property (wr_cfg
      |=> !dev_cfg_r[hdc_pkg::RSVD_ONE_BIT] && !dev_cfg_r[hdc_pkg::RSVD_ZERO_BIT])
    else $error("read-only bits stored a write");

  // pin mode refuses every write
  pin_mode_a: assert property (i_mode == hdc_pkg::HDC_MODE_PIN && !capture
      |=> $stable(dev_cfg_r) && $stable(chg_r))
    else $error("write accepted in pin mode");

  // other offsets leave the pair alone
  unmapped_wr_a: assert property (i_req.wr && addr_unmapped && !capture
      |=> $stable(dev_cfg_r) && $stable(chg_r))
    else $error("write to other offset changed the pair");

  // charge enables take the written bits
  chg_write_a: assert property (wr_chg && !capture
      |=> chg_r == $past(i_req.data[1:0]))
    else $error("charge write not taken");

  // read port shows the selected register
  rd_cfg_a: assert property (i_req.rd && i_req.addr == hdc_pkg::DEV_CFG_OFFSET
      |=> o_rdata == $past(dev_cfg_rd))
    else $error("config read data wrong");

  chg_rd_a: assert property (i_req.rd && i_req.addr == hdc_pkg::CHG_PORT_OFFSET
      |=> o_rdata[1:0] == $past(chg_r))
    else $error("charge read data wrong");

  unmapped_rd_a: assert property (i_req.rd && addr_unmapped
      |=> o_rdata == 8'h00)
    else $error("other offset read not zero");

  // read data stands until the next read
  rdata_hold_a: assert property (!i_req.rd
      |=> $stable(o_rdata))
    else $error("read data moved without a read");

  // u1/u2 blocked while disabled and not forced
  lp_block_a: assert property (lp_dis && !force_held_r && !i_force_accept
      |-> !o_link_lp_allow)
    else $error("u1/u2 allowed while disabled");

  lp_enabled_a: assert property (i_link_lp_request && !lp_dis
      |-> o_link_lp_allow)
    else $error("u1/u2 refused while enabled");

  no_req_a: assert property (!i_link_lp_request
      |-> !o_link_lp_allow)
    else $error("u1/u2 allowed with no request");

  // forced accept opens u1/u2 at once
  force_open_a: assert property (i_link_lp_request && (force_held_r || i_force_accept)
      |-> o_link_lp_allow)
    else $error("u1/u2 refused after forced accept");

  // forced accept held while no disconnect
  force_hold_a: assert property (i_force_accept ##1 !i_upstream_disconnect[*3]
      |-> force_held_r)
    else $error("forced accept dropped early");

  disc_clear_a: assert property (i_upstream_disconnect && !i_force_accept
      |=> !force_held_r)
    else $error("forced accept kept after disconnect");

  // ganged switching uses the port 1 pin only
  gang_a: assert property (pm_on && shared_sw && |i_port_power_req
      |=> pwr_r == 2'b01)
    else $error("ganged power not on port 1 pin");

  gang_idle_a: assert property (pm_on && shared_sw && !(|i_port_power_req)
      |=> pwr_r == 2'b00)
    else $error("ganged power on with no demand");

  // per-port switching follows each demand
  per_port_a: assert property (pm_on && !shared_sw
      |=> pwr_r == $past(i_port_power_req))
    else $error("per-port power does not follow demand");

  pm_off_a: assert property (!pm_on
      |=> pwr_r == 2'b00)
    else $error("power pins driven with switching off");

  // main scenarios reached
  smb_write_c: cover property (i_mode == hdc_pkg::HDC_MODE_SMBUS && wr_cfg);
  force_c:     cover property (lp_dis && i_force_accept);
  gang_c:      cover property (pm_on && shared_sw && |i_port_power_req);
  chg_wr_c:    cover property (wr_chg);
  strap_c:     cover property (capture);

endmodule

/* hdc_host_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// host model: eeprom loader or smbus master side
// ------------------------------------------------------------
module hdc_host_model (
  // clock
  input  wire logic         i_clk,
  // register access
  output hdc_pkg::hdc_req_s o_req,
  input  wire logic [7:0]   i_rdata
);
  // idle bus, strobes low
  initial o_req = '0;

  // one write strobe, raised and dropped at falling edges
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_req.wr   = 1'b1;
    o_req.addr = a;
    // bit 1 of device config kept at its default
    o_req.data = (a == hdc_pkg::DEV_CFG_OFFSET) ? (d & 8'hfd) : d;
    @(negedge i_clk);
    o_req.wr   = 1'b0;
    o_req.data = ~o_req.data; // stale data never left on the bus
  endtask

  // one read strobe, data taken one edge later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_clk);
    o_req.rd   = 1'b1;
    o_req.addr = a;
    @(negedge i_clk);
    o_req.rd   = 1'b0;
    o_req.addr = ~a;
    d          = i_rdata;
  endtask
endmodule

/* tb_hdc_config_regs.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// testbench for the configuration register pair
// ------------------------------------------------------------
module tb_hdc_config_regs;
  logic               i_clk;
  logic               i_rst_n;
  hdc_pkg::hdc_mode_e i_mode;
  hdc_pkg::hdc_req_s  req;
  logic [7:0]         o_rdata;
  hdc_pkg::hdc_strap_s i_strap;
  logic               frc, disc, lpreq, allow, swen, str_we, ser_we;
  logic [1:0]         preq, pins, chg;
  int                 err_count;
  int                 comparisons;
  logic [7:0]         v;

  // 10 mhz clock
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  hdc_config_regs hdc_config_regs_i (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_mode(i_mode), .i_req(req),
    .o_rdata(o_rdata), .i_strap(i_strap), .i_force_accept(frc),
    .i_upstream_disconnect(disc), .i_link_lp_request(lpreq),
    .o_link_lp_allow(allow), .i_port_power_req(preq),
    .o_port_power_charge(pins), .o_power_switching_en(swen),
    .o_string_write_enable(str_we), .o_serial_number_write_enable(ser_we),
    .o_charge_port_enables(chg));

  hdc_host_model hdc_host_model_i (.i_clk(i_clk), .o_req(req), .i_rdata(o_rdata));

  // byte compare, narrow results zero-extended
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // read one register and compare
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    hdc_host_model_i.rd(a, v);
    chk(v, exp);
  endtask

  task automatic report_and_stop;
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // watchdog cuts a hang short
  initial begin
    #(100 * 20000);
    err_count++;
    report_and_stop();
  end

  // main sequence
  initial begin
    err_count = 0;
    comparisons = 0;
    i_rst_n = 1'b0;
    i_mode  = hdc_pkg::HDC_MODE_PIN;
    i_strap = '{shared_power: 1'b1, power_mgmt: 1'b0, charge_enables: 2'b10};
    {frc, disc, lpreq} = 3'b000;
    preq = 2'b11;
    repeat (16) @(negedge i_clk);
    i_rst_n = 1'b1;
    repeat (8) @(negedge i_clk);
    // strap capture and fixed bits
    rchk(hdc_pkg::DEV_CFG_OFFSET, 8'h18);
    rchk(hdc_pkg::CHG_PORT_OFFSET, 8'h02);
    chk({6'h00, str_we, ser_we}, 8'h00);
    chk({6'h00, chg}, 8'h02);
    rchk(8'h07, 8'h00);
    // pin mode write refused
    hdc_host_model_i.wr(hdc_pkg::DEV_CFG_OFFSET, 8'hff);
    rchk(hdc_pkg::DEV_CFG_OFFSET, 8'h18);
    // smbus overwrite, read-only bits hold
    i_mode = hdc_pkg::HDC_MODE_SMBUS;
    hdc_host_model_i.wr(hdc_pkg::DEV_CFG_OFFSET, 8'hff);
    rchk(hdc_pkg::DEV_CFG_OFFSET, 8'hfc);
    chk({5'h00, str_we, ser_we, swen}, 8'h06);
    chk({6'h00, pins}, 8'h00);
    // per-port switching follows each demand
    hdc_host_model_i.wr(hdc_pkg::DEV_CFG_OFFSET, 8'h00);
    rchk(hdc_pkg::DEV_CFG_OFFSET, 8'h10);
    preq = 2'b10;
    repeat (2) @(negedge i_clk);
    chk({5'h00, swen, pins}, 8'h06);
    // shared switching drives port 1 pin only
    hdc_host_model_i.wr(hdc_pkg::DEV_CFG_OFFSET, 8'h08);
    repeat (2) @(negedge i_clk);
    chk({6'h00, pins}, 8'h01);
    // unmapped offset leaves device configuration alone
    hdc_host_model_i.wr(8'h07, 8'hff);
    rchk(hdc_pkg::DEV_CFG_OFFSET, 8'h18);
    // eeprom load in i2c mode
    i_mode = hdc_pkg::HDC_MODE_I2C;
    hdc_host_model_i.wr(hdc_pkg::CHG_PORT_OFFSET, 8'hff);
    rchk(hdc_pkg::CHG_PORT_OFFSET, 8'h03);
    chk({6'h00, chg}, 8'h03);
    hdc_host_model_i.wr(hdc_pkg::DEV_CFG_OFFSET, 8'h20);
    rchk(hdc_pkg::DEV_CFG_OFFSET, 8'h30);
    // link power requests blocked, then forced open
    lpreq = 1'b1;
    @(negedge i_clk);
    chk({7'h00, allow}, 8'h00);
    frc = 1'b1;
    @(negedge i_clk);
    chk({7'h00, allow}, 8'h01);
    frc = 1'b0;
    repeat (3) @(negedge i_clk);
    chk({7'h00, allow}, 8'h01);
    disc = 1'b1;
    @(negedge i_clk);
    disc = 1'b0;
    @(negedge i_clk);
    chk({7'h00, allow}, 8'h00);
    hdc_host_model_i.wr(hdc_pkg::DEV_CFG_OFFSET, 8'h00);
    @(negedge i_clk);
    chk({7'h00, allow}, 8'h01);
    // forced accept, then a power-on reset drops it and recaptures straps
    frc = 1'b1;
    @(negedge i_clk);
    frc = 1'b0;
    i_rst_n = 1'b0;
    i_strap = '{shared_power: 1'b0, power_mgmt: 1'b1, charge_enables: 2'b01};
    repeat (4) @(negedge i_clk);
    i_rst_n = 1'b1;
    repeat (8) @(negedge i_clk);
    rchk(hdc_pkg::DEV_CFG_OFFSET, 8'h14);
    rchk(hdc_pkg::CHG_PORT_OFFSET, 8'h01);
    chk({5'h00, swen, pins}, 8'h00);
    chk({6'h00, chg}, 8'h01);
    // string gate alone, link disabled again with no forced accept held
    hdc_host_model_i.wr(hdc_pkg::DEV_CFG_OFFSET, 8'ha0);
    @(negedge i_clk);
    chk({6'h00, str_we, ser_we}, 8'h02);
    chk({7'h00, allow}, 8'h00);
    rchk(hdc_pkg::DEV_CFG_OFFSET, 8'hb0);
    report_and_stop();
  end
endmodule
